// *** hdl/lfr_latched_fault_reaction.sv ***
// Purpose: latched overcurrent fault reaction for an H-bridge driver
// Assumes: 100 MHz clk, synchronous active-high srst
// Notes:   pins pass a two-flop synchroniser; the serial command is
//          a same-domain pulse
`timescale 1ns/1ps
`include "lfr_params.svh"
// Contract
// (RQ1) A deglitched overcurrent turns the output off and drives fault low.
// (RQ2) An acknowledge releases the fault line and re-enables the output.
// (RQ3) A short still present after acknowledgement trips again.
// (RQ4) A short gone before the ack leaves the output on with no new fault.
// (RQ5) Serial-variant status bits stay latched until a clear command.
// (RQ6) A short-to-ground trip holds sense at its limit while output is off.
// (RQ7) Serial copies flag frame errors and lock config and driver bits.
// (RQ8) The external-supply variant has no sleep pin nor undervoltage reset.
// (RQ9) The controller keeps its sleep-pin pulse short of the sleep time.
module lfr_latched_fault_reaction #(
    parameter lfr_pkg::lfr_variant_e VARIANT    = lfr_pkg::LFR_VAR_SPI_S,
    parameter int                    DEGLITCH   = `LFR_OCP_DEGLITCH_CYC,
    parameter int                    SLEEP_MAX  = `LFR_SLEEP_PULSE_MAX_CYC
) (
    input  wire logic                   clk,
    input  wire logic                   srst,
    input  wire logic                   overcurrentProtection,
    input  wire logic                   highSideShortGnd,
    input  wire logic                   sleepControlPin,
    input  wire logic                   mainSupplyUv,
    input  wire logic                   clearFaultCommand,
    input  wire logic                   frameError,
    input  wire logic                   lockEnable,
    input  wire logic                   cfgWriteReq,
    input  wire logic [7:0]             cfgWriteData,
    output logic                        outputEnable,
    output logic                        faultIndicatorLowOut,
    output logic                        faultIndicatorLowOe,
    output logic                        currentSenseAtLimit,
    output logic                        sleepState,
    output logic [`LFR_STAT_W-1:0]      faultStatus,
    output logic [7:0]                  cfgReg,
    output logic                        logicReset
);
    localparam bit IS_HW  = (VARIANT == lfr_pkg::LFR_VAR_HW);
    localparam bit IS_SPI = !IS_HW;
    localparam bit HAS_SLEEP = (VARIANT != lfr_pkg::LFR_VAR_SPI_P);

    logic [3:0] syncOut;
    logic       ocpS;
    logic       gndS;
    logic       sleepS;
    logic       uvS;
    logic       sleepPrev;
    logic [`LFR_CNT_W-1:0] ocpCnt;
    logic [`LFR_CNT_W-1:0] lowCnt;
    logic       ocpConfirmed;
    logic       sleepPulse;
    logic       ack;
    logic       shortGndTrip;
    lfr_pkg::lfr_state_e state;

    lfr_sync #(
        .WIDTH (4)
    ) u_sync (
        .clk  (clk),
        .srst (srst),
        // sleep pin inverted: flops reset to its idle high, no false edge
        .din  ({mainSupplyUv, !sleepControlPin, highSideShortGnd,
                overcurrentProtection}),
        .dout (syncOut)
    );
    assign ocpS   = syncOut[0];
    assign gndS   = syncOut[1];
    assign sleepS = HAS_SLEEP ? !syncOut[2] : 1'b1; // RQ8
    assign uvS    = syncOut[3];

    // deglitch counter: runs only in LFR_RUN, sleeping or not, while overcurrent seen
    always_ff @(posedge clk) begin
        if (srst) begin
            ocpCnt <= '0;
        end else if (!ocpS || state != lfr_pkg::LFR_RUN || ack) begin
            ocpCnt <= '0;
        end else if (!ocpConfirmed) begin
            ocpCnt <= ocpCnt + `LFR_CNT_W'(1);
        end
    end
    assign ocpConfirmed = (ocpCnt >= `LFR_CNT_W'(DEGLITCH - 1)) && ocpS; // RQ1

    // sleep-pin low time: short pulse acknowledges (hardwired variant only), long low sleeps
    always_ff @(posedge clk) begin
        if (srst) begin
            sleepPrev <= 1'b1;
            lowCnt    <= '0;
        end else begin
            sleepPrev <= sleepS;
            if (sleepS) begin
                lowCnt <= '0;
            end else if (lowCnt != '1) begin
                lowCnt <= lowCnt + `LFR_CNT_W'(1);
            end
        end
    end
    assign sleepState = !sleepS && (lowCnt >= `LFR_CNT_W'(SLEEP_MAX));
    // rising edge after a short low ends the pulse; RQ9 keeps it short
    assign sleepPulse = HAS_SLEEP && sleepS && !sleepPrev
                        && (lowCnt < `LFR_CNT_W'(SLEEP_MAX)); // RQ9
    assign ack = IS_HW ? sleepPulse : clearFaultCommand; // RQ2

    // latched fault machine
    always_ff @(posedge clk) begin
        if (srst) begin
            state        <= lfr_pkg::LFR_RUN;
            shortGndTrip <= 1'b0;
        end else begin
            case (state)
                lfr_pkg::LFR_RUN: begin
                    if (ocpConfirmed && !sleepState) begin
                        state        <= lfr_pkg::LFR_FAULT; // RQ1 RQ3
                        shortGndTrip <= gndS; // RQ6
                    end
                end
                lfr_pkg::LFR_FAULT: begin
                    if (ack) begin
                        state        <= lfr_pkg::LFR_RUN; // RQ2 RQ4
                        shortGndTrip <= 1'b0;
                    end
                end
                default: begin
                    state        <= lfr_pkg::LFR_RUN;
                    shortGndTrip <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            outputEnable         <= 1'b0;
            faultIndicatorLowOe  <= 1'b0;
            currentSenseAtLimit  <= 1'b0;
        end else begin
            outputEnable <= (state == lfr_pkg::LFR_RUN) && !ocpConfirmed
                            && !sleepState; // RQ1 RQ4
            faultIndicatorLowOe <= (state == lfr_pkg::LFR_FAULT && !ack)
                                   || (state == lfr_pkg::LFR_RUN
                                       && ocpConfirmed); // RQ1 RQ2
            currentSenseAtLimit <= (state == lfr_pkg::LFR_FAULT && !ack
                                    && shortGndTrip)
                                   || (state == lfr_pkg::LFR_RUN
                                       && ocpConfirmed && gndS); // RQ6
        end
    end
    assign faultIndicatorLowOut = 1'b0;

    // status bits: set wins over clear
    always_ff @(posedge clk) begin
        if (srst) begin
            faultStatus <= '0;
        end else if (IS_SPI) begin
            faultStatus <= (clearFaultCommand ? '0 : faultStatus) // RQ5
                | {`LFR_STAT_W{1'b0}}
                | (`LFR_STAT_W'(ocpConfirmed) << `LFR_STAT_OCP)
                | (`LFR_STAT_W'(ocpConfirmed && gndS) << `LFR_STAT_SHORTGND)
                | (`LFR_STAT_W'(frameError) << `LFR_STAT_FRAME) // RQ7
                | (`LFR_STAT_W'(cfgWriteReq && lockEnable)
                   << `LFR_STAT_LOCKVIOL); // RQ7
        end
    end

    // lockable configuration and driver bits
    always_ff @(posedge clk) begin
        if (srst) begin
            cfgReg <= `LFR_CFG_RESET;
        end else if (IS_SPI && cfgWriteReq && !lockEnable
                     && !frameError) begin
            cfgReg <= cfgWriteData; // RQ7
        end
    end

    // digital reset request on main undervoltage, not for external supply
    always_ff @(posedge clk) begin
        if (srst) begin
            logicReset <= 1'b0;
        end else begin
            logicReset <= uvS && (VARIANT != lfr_pkg::LFR_VAR_SPI_P); // RQ8
        end
    end

    a_trip_on_confirm: assert property (@(posedge clk) // RQ1
        disable iff (srst)
        (state == lfr_pkg::LFR_RUN && ocpConfirmed && !sleepState)
        |=> faultIndicatorLowOe && !outputEnable)
        else $error("trip did not drop output and raise fault");
    a_clear_releases: assert property (@(posedge clk) // RQ2
        disable iff (srst)
        (state == lfr_pkg::LFR_FAULT && ack)
        |=> !faultIndicatorLowOe)
        else $error("acknowledge did not release fault line");
    sequence s_ackNoShort;
        state == lfr_pkg::LFR_FAULT && ack && !ocpS;
    endsequence
    a_no_retrip: assert property (@(posedge clk) // RQ4
        disable iff (srst)
        s_ackNoShort ##1 (!ocpS && !sleepState)[*2] |=> outputEnable)
        else $error("output not re-enabled after clean clear");
    a_retrip_again: assert property (@(posedge clk) // RQ3
        disable iff (srst)
        (state == lfr_pkg::LFR_RUN && ocpS && !sleepState && !ack)[*2]
        ##0 ocpConfirmed |=> state == lfr_pkg::LFR_FAULT)
        else $error("short after clear did not trip again");
    a_status_hold: assert property (@(posedge clk) // RQ5
        disable iff (srst)
        (IS_SPI && faultStatus[`LFR_STAT_OCP] && !clearFaultCommand)
        |=> faultStatus[`LFR_STAT_OCP])
        else $error("status bit dropped without clear");
    a_sense_limit: assert property (@(posedge clk) // RQ6
        disable iff (srst)
        currentSenseAtLimit |-> !outputEnable)
        else $error("sense at limit while output enabled");
    a_sense_release: assert property (@(posedge clk) // RQ6
        disable iff (srst)
        (state == lfr_pkg::LFR_FAULT && ack)
        |=> !currentSenseAtLimit)
        else $error("acknowledge did not release sense limit");
    a_lock_blocks: assert property (@(posedge clk) // RQ7
        disable iff (srst)
        (lockEnable && cfgWriteReq) |=> $stable(cfgReg))
        else $error("locked configuration changed");
    a_frame_flag: assert property (@(posedge clk) // RQ7
        disable iff (srst)
        (IS_SPI && frameError) |=> faultStatus[`LFR_STAT_FRAME])
        else $error("frame error not flagged");
    a_no_uv_reset: assert property (@(posedge clk) // RQ8
        disable iff (srst)
        (VARIANT == lfr_pkg::LFR_VAR_SPI_P) |-> !logicReset)
        else $error("external-supply variant reset on undervoltage");
endmodule : lfr_latched_fault_reaction

// *** hdl/lfr_params.svh ***
// Purpose: constants for the latched fault reaction block
// Assumes: 100 MHz clk
// Notes:   times in ns, cycle counts derived from them
`ifndef LFR_PARAMS_SVH
`define LFR_PARAMS_SVH
`define LFR_CLK_PERIOD_NS      10
`define LFR_OCP_DEGLITCH_NS    2000
`define LFR_OCP_DEGLITCH_CYC \
    ((`LFR_OCP_DEGLITCH_NS + `LFR_CLK_PERIOD_NS - 1) / `LFR_CLK_PERIOD_NS)
`define LFR_SLEEP_PULSE_MAX_NS 40000
`define LFR_SLEEP_PULSE_MAX_CYC (`LFR_SLEEP_PULSE_MAX_NS / `LFR_CLK_PERIOD_NS)
`define LFR_CNT_W              16
`define LFR_STAT_W             4
`define LFR_STAT_OCP           0
`define LFR_STAT_SHORTGND      1
`define LFR_STAT_FRAME         2
`define LFR_STAT_LOCKVIOL      3
`define LFR_CFG_RESET          8'h00
`endif

// *** hdl/lfr_pkg.sv ***
// Purpose: types for the latched fault reaction block
// Assumes: nothing
// Notes:   states of the fault machine
package lfr_pkg;
    typedef enum logic [1:0] {
        LFR_RUN,
        LFR_FAULT
    } lfr_state_e;
    typedef enum logic [1:0] {
        LFR_VAR_HW,
        LFR_VAR_SPI_S,
        LFR_VAR_SPI_P
    } lfr_variant_e;
endpackage : lfr_pkg

// *** hdl/lfr_sync.sv ***
// Purpose: two-flop synchroniser bank for asynchronous pins
// Assumes: single clock
// Notes:   first stage read only by second stage
`timescale 1ns/1ps
module lfr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_ff @(posedge clk) begin
                if (srst) begin
                    stage1[gi] <= 1'b0;
                    dout[gi]   <= 1'b0;
                end else begin
                    stage1[gi] <= din[gi];
                    dout[gi]   <= stage1[gi];
                end
            end
        end
    endgenerate
endmodule : lfr_sync

// *** dv/lfr_ctrl_model.sv ***
// Purpose: controller model acknowledging latched faults
// Assumes: clk shared with the block
// Notes:   ackSpi clear pulse, ackHw short sleep-pin pulse, sleepReq long low
`timescale 1ns/1ps
module lfr_ctrl_model #(
    parameter int PULSE = 5
) (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic ackSpi,
    input  wire logic ackHw,
    input  wire logic sleepReq,
    output logic      clearFaultCommand,
    output logic      sleepControlPin
);
    int cnt;
    always_ff @(posedge clk) begin
        if (srst) begin
            clearFaultCommand <= 1'b0;
            sleepControlPin   <= 1'b1;
            cnt               <= 0;
        end else begin
            clearFaultCommand <= ackSpi;
            if (ackHw) cnt <= PULSE;
            else if (cnt != 0) cnt <= cnt - 1;
            // low for PULSE cycles, well below the sleep entry time
            sleepControlPin <= !(ackHw || cnt > 1 || sleepReq);
        end
    end
endmodule : lfr_ctrl_model

// *** dv/latched_fault_reaction_tb.sv ***
// Purpose: self-checking bench for the latched fault reaction
// Assumes: DEGLITCH 4, SLEEP_MAX 20, two serial copies (one external-supply) and one hardwired copy
// Notes:   xorshift stimulus with fixed seed
`timescale 1ns/1ps
module latched_fault_reaction_tb;
    localparam int DEG = 4;
    logic clk = 0, srst = 1, overcurrent_protection = 0, sgnd = 0, uv = 0, frm = 0, lock = 0;
    logic wr = 0, ackSpi = 0, ackHw = 0, clr, slp, oeS, oeH, fS, fH, senS;
    logic rstS, oeP, rstP, senH, slpH, fOut, slpReq = 0;
    logic [7:0] wdata = 8'h00, cfg, expCfg;
    logic [3:0] stS;
    logic [31:0] seed = 32'h5b5effe2;
    int n_errors = 0, cmp_count = 0, cyc = 0;
    always #5 clk = ~clk;
    lfr_latched_fault_reaction #(.VARIANT(lfr_pkg::LFR_VAR_SPI_S),
        .DEGLITCH(DEG), .SLEEP_MAX(20)) dut (.clk(clk), .srst(srst),
        .overcurrentProtection(overcurrent_protection), .highSideShortGnd(sgnd),
        .sleepControlPin(1'b1), .mainSupplyUv(uv), .clearFaultCommand(clr),
        .frameError(frm), .lockEnable(lock), .cfgWriteReq(wr),
        .cfgWriteData(wdata), .outputEnable(oeS), .faultIndicatorLowOut(fOut),
        .faultIndicatorLowOe(fS), .currentSenseAtLimit(senS),
        .sleepState(), .faultStatus(stS), .cfgReg(cfg), .logicReset(rstS));
    lfr_latched_fault_reaction #(.VARIANT(lfr_pkg::LFR_VAR_HW),
        .DEGLITCH(DEG), .SLEEP_MAX(20)) dutHw (.clk(clk), .srst(srst),
        .overcurrentProtection(overcurrent_protection), .highSideShortGnd(sgnd),
        .sleepControlPin(slp), .mainSupplyUv(1'b0),
        .clearFaultCommand(clr), .frameError(frm), .lockEnable(lock),
        .cfgWriteReq(wr), .cfgWriteData(wdata), .outputEnable(oeH),
        .faultIndicatorLowOut(), .faultIndicatorLowOe(fH),
        .currentSenseAtLimit(senH), .sleepState(slpH),
        .faultStatus(), .cfgReg(), .logicReset());
    lfr_latched_fault_reaction #(.VARIANT(lfr_pkg::LFR_VAR_SPI_P),
        .DEGLITCH(DEG), .SLEEP_MAX(20)) dutP (.clk(clk), .srst(srst),
        .overcurrentProtection(overcurrent_protection), .highSideShortGnd(sgnd),
        .sleepControlPin(1'b0), .mainSupplyUv(uv), .clearFaultCommand(clr),
        .frameError(frm), .lockEnable(lock), .cfgWriteReq(wr),
        .cfgWriteData(wdata), .outputEnable(oeP), .faultIndicatorLowOut(),
        .faultIndicatorLowOe(), .currentSenseAtLimit(), .sleepState(),
        .faultStatus(), .cfgReg(), .logicReset(rstP));
    lfr_ctrl_model #(.PULSE(5)) ctrl (.clk(clk), .srst(srst),
        .ackSpi(ackSpi), .ackHw(ackHw), .clearFaultCommand(clr),
        .sleepReq(slpReq), .sleepControlPin(slp));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic step();
        @(posedge clk);
    endtask : step
    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        #1;
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // waits on the fault line of one copy, reports it afterwards
    task automatic wait_flt(input int hw, input logic v, input int lim);
        int n;
        n = 0;
        while (((hw != 0) ? fH : fS) !== v && n < lim) begin
            step();
            #1;
            n++;
        end
        chk("faultLine", {7'h0, v}, {7'h0, (hw != 0) ? fH : fS});
    endtask : wait_flt
    task automatic tally_and_finish();
        if (n_errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : tally_and_finish
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (2) step();
        srst <= 1'b0;
        repeat (4) step();
        for (int i = 0; i < 6; i++) begin
            overcurrent_protection <= 1'b1;
            repeat (1 + xs() % (DEG - 1)) step();
            overcurrent_protection <= 1'b0;
            repeat (1 + xs() % 4) step();
        end
        repeat (6) step();
        chk("outEnGlitch", 8'h01, {7'h0, oeS});
        chk("outEnNoPinP", 8'h01, {7'h0, oeP});
        step();
        sgnd <= 1'b1;
        overcurrent_protection  <= 1'b1;
        repeat (DEG + 8) step();
        chk("outEnTrip", 8'h00, {7'h0, oeS});
        chk("faultTrip", 8'h01, {7'h0, fS});
        chk("statusTrip", 8'h03, {4'h0, stS});
        chk("senseLimit", 8'h01, {7'h0, senS});
        chk("hwTrip", 8'h01, {7'h0, fH});
        chk("hwSense", 8'h01, {7'h0, senH});
        chk("faultOut", 8'h00, {7'h0, fOut});
        step();
        ackSpi <= 1'b1;
        step();
        ackSpi <= 1'b0;
        wait_flt(0, 1'b0, 6);
        chk("hwIgnoresClr", 8'h01, {7'h0, fH});
        wait_flt(0, 1'b1, DEG + 8);
        chk("outEnRetrip", 8'h00, {7'h0, oeS});
        step();
        overcurrent_protection  <= 1'b0;
        sgnd <= 1'b0;
        repeat (10) step();
        chk("statusHeld", 8'h03, {4'h0, stS});
        chk("senseHeld", 8'h01, {7'h0, senS});
        step();
        ackSpi <= 1'b1;
        ackHw  <= 1'b1;
        step();
        ackSpi <= 1'b0;
        ackHw  <= 1'b0;
        wait_flt(0, 1'b0, 6);
        wait_flt(1, 1'b0, 15);
        repeat (DEG + 6) step();
        chk("outEnBack", 8'h01, {7'h0, oeS});
        chk("hwOutEnBack", 8'h01, {7'h0, oeH});
        chk("faultStays", 8'h00, {7'h0, fS});
        chk("statusClr", 8'h00, {4'h0, stS});
        step();
        frm <= 1'b1;
        step();
        frm <= 1'b0;
        step();
        chk("frameFlag", 8'h04, {4'h0, stS});
        expCfg = cfg;
        for (int i = 0; i < 6; i++) begin
            step();
            lock  <= i[0];
            wr    <= 1'b1;
            wdata <= 8'(xs());
            step();
            if (!i[0]) expCfg = wdata;
            wr   <= 1'b0;
            lock <= 1'b0;
            step();
            chk("cfgReg", expCfg, cfg);
            chk("lockFlag", {7'h0, i >= 1}, {7'h0, stS[3]});
        end
        step();
        slpReq <= 1'b1;
        repeat (30) step();
        chk("hwSleep", 8'h01, {7'h0, slpH});
        chk("hwSleepOff", 8'h00, {7'h0, oeH});
        step();
        slpReq <= 1'b0;
        repeat (8) step();
        chk("hwWake", 8'h00, {7'h0, slpH});
        chk("hwWakeOn", 8'h01, {7'h0, oeH});
        step();
        uv <= 1'b1;
        repeat (5) step();
        chk("uvReset", 8'h01, {7'h0, rstS});
        chk("uvNoResetP", 8'h00, {7'h0, rstP});
        tally_and_finish();
    end
endmodule : latched_fault_reaction_tb
